// *** src/pus_sequencer.sv ***
// power-up slot sequencer with slave mode and standby/run handling
// Function
// - nonzero code gives slot code-1; code 1 starts at once, 255 is 254.
// - unslotted MCU reset releases after the last slotted regulator.
// - all regulator and power-good codes zero: run in slave mode, none on.
// - slave mode releases an unslotted MCU reset on entering run.
// - standby to run starts the sequencer only if a regulator turns on.
// - voltage-only standby changes apply at once, bypassing the sequencer.
// - code zero keeps a regulator off and the power-good pin low.
// - time base 00..11 selects 30, 120, 250 or 500 us steps.
// - power-up-complete flag pulses at end of every standby to run.
`timescale 1ns/1ns
`include "pus_consts.svh"

module pus_sequencer
   import pus_pkg::*;
#(
   parameter logic [`PUS_CNT_W-1:0] TB2_CYC = `PUS_CNT_W'(`PUS_TB2_CYC),
   parameter logic [`PUS_CNT_W-1:0] TB3_CYC = `PUS_CNT_W'(`PUS_TB3_CYC)
)
(
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire pus_slots_s SLOTS,
   input wire logic POWER_ON_EVENT,
   input wire logic RUN_REQ,
   input wire logic STBY_REQ,
   input wire logic [3:0] RUN_ON_MASK,
   input wire logic [3:0] STBY_ON_MASK,
   output logic [3:0] REG_EN,
   output logic POWER_GOOD_PIN,
   output logic MCU_RESET_OUTPUT_N,
   output logic SLAVE_MODE,
   output logic RUN_STATE,
   output logic VOLT_APPLY,
   output logic POWER_UP_COMPLETE_FLAG
);
   // slot hit decode, code zero never hits
   function automatic logic slot_hit(input logic [7:0] code,
                                     input logic [7:0] slot);
      slot_hit = (code != `PUS_CODE_OFF) && ((code - 8'h01) == slot);
   endfunction
   function automatic logic [`PUS_CNT_W-1:0] tb_cycles(input logic [1:0] s);
      case (s)
         2'h0: tb_cycles = `PUS_CNT_W'(`PUS_TB0_CYC);
         2'h1: tb_cycles = `PUS_CNT_W'(`PUS_TB1_CYC);
         2'h2: tb_cycles = TB2_CYC;
         default: tb_cycles = TB3_CYC;
      endcase
   endfunction

   pus_state_e state_reg, state_next;
   logic [`PUS_CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] slot_reg, slot_next, end_slot_reg, end_slot_next;
   logic [7:0] rst_slot_reg, rst_slot_next;
   logic [3:0] mask_reg, mask_next, reg_en_reg, reg_en_next;
   logic rst_seq_reg, rst_seq_next, pg_reg, pg_next, rst_n_reg, rst_n_next;
   logic slave_reg, slave_next, volt_reg, volt_next, done_reg, done_next;
   logic run_reg, run_next;
   logic [3:0] hit_w, toggle_w;
   logic [`PUS_CNT_W-1:0] tb_w;
   logic all_zero_w;
   assign tb_w = tb_cycles(SLOTS.sequencer_time_base);
   assign all_zero_w = (SLOTS.regulator_slot_code == '0) &&
      (SLOTS.power_good_output_slot_code == `PUS_CODE_OFF);
   assign toggle_w = RUN_ON_MASK & ~reg_en_reg;

   genvar gi;
   generate
      for (gi = 0; gi < `PUS_NUM_REG; gi++)
      begin : g_hit
         assign hit_w[gi] = mask_reg[gi] &&
            slot_hit(SLOTS.regulator_slot_code[gi], slot_reg);
      end
   endgenerate
   // end slot and reset slot of a new sequence
   function automatic void plan(input pus_slots_s sl, input logic [3:0] m,
      input logic with_pg_rst, output logic [7:0] end_o,
      output logic [7:0] rst_o);
      logic [7:0] last;
      logic found;
      last = 8'h00;
      found = 1'b0;
      for (int i = 0; i < `PUS_NUM_REG; i++)
      begin
         if (m[i] && sl.regulator_slot_code[i] != `PUS_CODE_OFF)
         begin
            found = 1'b1;
            if (sl.regulator_slot_code[i] - 8'h01 > last)
               last = sl.regulator_slot_code[i] - 8'h01;
         end
      end
      end_o = last;
      rst_o = last;
      if (with_pg_rst)
      begin
         if (sl.power_good_output_slot_code != `PUS_CODE_OFF &&
             sl.power_good_output_slot_code - 8'h01 > last)
            end_o = sl.power_good_output_slot_code - 8'h01;
         if (sl.mcu_reset_slot_code != `PUS_CODE_OFF)
            rst_o = sl.mcu_reset_slot_code - 8'h01;
         // default release one slot after last regulator
         else if (found)
            rst_o = last + 8'h01;
         if (rst_o > end_o)
            end_o = rst_o;
      end
   endfunction
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      slot_next = slot_reg;
      end_slot_next = end_slot_reg;
      rst_slot_next = rst_slot_reg;
      rst_seq_next = rst_seq_reg;
      mask_next = mask_reg;
      reg_en_next = reg_en_reg;
      pg_next = pg_reg;
      rst_n_next = rst_n_reg;
      slave_next = slave_reg;
      volt_next = 1'b0;
      done_next = 1'b0;
      case (state_reg)
         ST_OFF:
            if (POWER_ON_EVENT)
            begin
               cnt_next = '0;
               slot_next = 8'h00;
               plan(SLOTS, 4'hf, 1'b1, end_slot_next, rst_slot_next);
               mask_next = 4'hf;
               rst_seq_next = 1'b1;
               slave_next = all_zero_w;
               // slave mode enters run with nothing enabled
               if (all_zero_w &&
                   SLOTS.mcu_reset_slot_code == `PUS_CODE_OFF)
               begin
                  state_next = ST_RUN;
                  // unslotted reset released on run entry
                  rst_n_next = 1'b1;
                  done_next = 1'b1;
               end
               else
                  state_next = ST_SEQ;
            end
         ST_SEQ:
         begin
            // code zero never hits, output stays off
            reg_en_next = reg_en_reg | hit_w;
            if (rst_seq_reg &&
                slot_hit(SLOTS.power_good_output_slot_code, slot_reg))
               pg_next = 1'b1;
            if (rst_seq_reg && slot_reg == rst_slot_reg)
               rst_n_next = 1'b1;
            if (slot_reg == end_slot_reg)
            begin
               state_next = ST_RUN;
               done_next = 1'b1;
            end
            // one slot per time base step
            else if (cnt_reg >= tb_w - `PUS_CNT_W'(1))
            begin
               cnt_next = '0;
               slot_next = slot_reg + 8'h01;
            end
            else
               cnt_next = cnt_reg + `PUS_CNT_W'(1);
         end
         ST_RUN:
            if (STBY_REQ)
            begin
               reg_en_next = reg_en_reg & STBY_ON_MASK;
               volt_next = 1'b1;
               state_next = ST_STBY;
            end
         ST_STBY:
            if (RUN_REQ)
            begin
               volt_next = 1'b1;
               // sequence only regulators that turn on
               if (toggle_w != 4'h0)
               begin
                  cnt_next = '0;
                  slot_next = 8'h00;
                  plan(SLOTS, toggle_w, 1'b0, end_slot_next, rst_slot_next);
                  mask_next = toggle_w;
                  rst_seq_next = 1'b0;
                  state_next = ST_SEQ;
               end
               else
               begin
                  state_next = ST_RUN;
                  done_next = 1'b1;
               end
            end
         default:
            state_next = ST_OFF;
      endcase
      run_next = (state_next == ST_RUN);
   end

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_reg <= ST_OFF;
         cnt_reg <= '0;
         slot_reg <= 8'h00;
         end_slot_reg <= 8'h00;
         rst_slot_reg <= 8'h00;
         rst_seq_reg <= 1'b0;
         run_reg <= 1'b0;
         mask_reg <= 4'h0;
         reg_en_reg <= 4'h0;
         pg_reg <= 1'b0;
         rst_n_reg <= 1'b0;
         slave_reg <= 1'b0;
         volt_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         slot_reg <= slot_next;
         end_slot_reg <= end_slot_next;
         rst_slot_reg <= rst_slot_next;
         rst_seq_reg <= rst_seq_next;
         run_reg <= run_next;
         mask_reg <= mask_next;
         reg_en_reg <= reg_en_next;
         pg_reg <= pg_next;
         rst_n_reg <= rst_n_next;
         slave_reg <= slave_next;
         volt_reg <= volt_next;
         done_reg <= done_next;
      end
   end

   assign REG_EN = reg_en_reg;
   assign POWER_GOOD_PIN = pg_reg;
   assign MCU_RESET_OUTPUT_N = rst_n_reg;
   assign SLAVE_MODE = slave_reg;
   assign RUN_STATE = run_reg;
   assign VOLT_APPLY = volt_reg;
   assign POWER_UP_COMPLETE_FLAG = done_reg;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   sequence s_power_on;
      state_reg == ST_OFF && POWER_ON_EVENT;
   endsequence
   sequence s_run_req;
      state_reg == ST_STBY && RUN_REQ;
   endsequence
   chk_slot0_start: assert property (
      s_power_on and SLOTS.regulator_slot_code[0] == 8'h01 && !all_zero_w
      |-> ##2 REG_EN[0])
      else $error("slot zero regulator not enabled at once");
   chk_enable_slot: assert property (
      $rose(REG_EN[0]) |->
      $past(slot_reg) == $past(SLOTS.regulator_slot_code[0]) - 8'h01)
      else $error("regulator enabled in wrong slot");
   chk_step_time: assert property (
      state_reg == ST_SEQ && slot_reg != end_slot_reg &&
      slot_next != slot_reg |-> cnt_reg >= tb_w - `PUS_CNT_W'(1))
      else $error("slot advanced before time base elapsed");
   chk_code_zero: assert property (
      $rose(POWER_GOOD_PIN) |->
      $past(SLOTS.power_good_output_slot_code) != `PUS_CODE_OFF)
      else $error("power-good driven with code zero");
   chk_rst_default: assert property (
      $rose(MCU_RESET_OUTPUT_N) && !SLAVE_MODE |->
      $past(slot_reg) == $past(rst_slot_reg))
      else $error("reset released outside its slot");
   chk_slave_entry: assert property (
      s_power_on and all_zero_w |-> ##1 SLAVE_MODE && REG_EN == 4'h0
      && !POWER_GOOD_PIN)
      else $error("slave mode entry wrong");
   chk_slave_reset: assert property (
      s_power_on and all_zero_w &&
      SLOTS.mcu_reset_slot_code == `PUS_CODE_OFF
      |-> ##1 RUN_STATE && MCU_RESET_OUTPUT_N)
      else $error("slave reset not released on run entry");
   chk_seq_start: assert property (
      s_run_req and toggle_w != 4'h0 |-> ##1 state_reg == ST_SEQ)
      else $error("sequencer not started for regulator turn-on");
   chk_bypass: assert property (
      s_run_req and toggle_w == 4'h0 |-> ##1 RUN_STATE && VOLT_APPLY)
      else $error("voltage-only transition not immediate");
   chk_done_flag: assert property (
      RUN_STATE && !$past(RUN_STATE) |-> POWER_UP_COMPLETE_FLAG)
      else $error("power-up complete flag missing");

endmodule // pus_sequencer

// *** src/pus_consts.svh ***
// timing and code constants for the power-up slot sequencer
`ifndef PUS_CONSTS_SVH
`define PUS_CONSTS_SVH
`define PUS_CLK_MHZ 20
`define PUS_TB0_US 30
`define PUS_TB1_US 120
`define PUS_TB2_US 250
`define PUS_TB3_US 500
`define PUS_TB0_CYC (`PUS_TB0_US * `PUS_CLK_MHZ)
`define PUS_TB1_CYC (`PUS_TB1_US * `PUS_CLK_MHZ)
`define PUS_TB2_CYC (`PUS_TB2_US * `PUS_CLK_MHZ)
`define PUS_TB3_CYC (`PUS_TB3_US * `PUS_CLK_MHZ)
`define PUS_CODE_OFF 8'h00
`define PUS_NUM_REG 4
`define PUS_CNT_W 14
`endif

// *** src/pus_pkg.sv ***
// types for the power-up slot sequencer
package pus_pkg;
   typedef struct packed {
      logic [3:0][7:0] regulator_slot_code;
      logic [7:0] power_good_output_slot_code;
      logic [7:0] mcu_reset_slot_code;
      logic [1:0] sequencer_time_base;
   } pus_slots_s;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_SEQ = 2'b01,
      ST_RUN = 2'b10,
      ST_STBY = 2'b11
   } pus_state_e;
endpackage

// *** verification/pus_loads.sv ***
// load-side model recording when each sequenced output switches on
`timescale 1ns/1ns
module pus_loads
(
   input wire logic mclk,
   input wire logic start,
   input wire logic [3:0] reg_en,
   input wire logic pg,
   input wire logic rst_n_out,
   output int t_reg [4],
   output int t_pg,
   output int t_rst
);
   int cnt;
   logic [5:0] prev;
   // rise times in edges after the start edge, -1 if none
   always @(posedge mclk)
   begin
      if (start)
      begin
         cnt <= 0;
         t_reg <= '{-1, -1, -1, -1};
         t_pg <= -1;
         t_rst <= -1;
      end
      else
      begin
         cnt <= cnt + 1;
         for (int i = 0; i < 4; i++)
            if (reg_en[i] && !prev[i])
               t_reg[i] <= cnt;
         if (pg && !prev[4])
            t_pg <= cnt;
         if (rst_n_out && !prev[5])
            t_rst <= cnt;
      end
      prev <= {rst_n_out, pg, reg_en};
   end
endmodule // pus_loads

// *** verification/test_power_up_slot_sequencer.sv ***
// self-checking bench for the power-up slot sequencer
`timescale 1ns/1ns
module test_power_up_slot_sequencer
   import pus_pkg::*;
;
   localparam int T2 = 20;
   localparam int T3 = 40;
   logic mclk, reset_n, pg, rst_o, slave, run_st, volt, flag;
   logic [2:0] req;
   logic [3:0] run_mask, stby_mask, reg_en;
   pus_slots_s slots;
   int t_reg [4];
   int t_pg, t_rst, n_errors, cmp_count, seed;

   pus_sequencer #(.TB2_CYC(14'(T2)), .TB3_CYC(14'(T3))) uut
   (
      .MCLK(mclk), .RESET_N(reset_n), .SLOTS(slots),
      .POWER_ON_EVENT(req[0]), .RUN_REQ(req[1]), .STBY_REQ(req[2]),
      .RUN_ON_MASK(run_mask), .STBY_ON_MASK(stby_mask), .REG_EN(reg_en),
      .POWER_GOOD_PIN(pg), .MCU_RESET_OUTPUT_N(rst_o), .SLAVE_MODE(slave),
      .RUN_STATE(run_st), .VOLT_APPLY(volt), .POWER_UP_COMPLETE_FLAG(flag)
   );
   pus_loads loads
   (
      .mclk(mclk), .start(|req), .reg_en(reg_en), .pg(pg),
      .rst_n_out(rst_o), .t_reg(t_reg), .t_pg(t_pg), .t_rst(t_rst)
   );

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   function automatic int xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected rise edge after the event edge: 1 + slot * step
   function automatic int at(int code, int tc);
      return 1 + (code - 1) * tc;
   endfunction

   function automatic int tcyc(int tb);
      int q [$] = '{30 * 20, 120 * 20, T2, T3};
      return q[tb];
   endfunction

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic hw_reset();
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
   endtask

   task automatic pulse(logic [2:0] v);
      @(posedge mclk);
      req <= v;
      @(posedge mclk);
      req <= 3'h0;
   endtask

   task automatic wait_flag(int bound);
      int i;
      for (i = 0; i < bound; i++)
      begin
         @(negedge mclk);
         if (flag === 1'b1)
            break;
      end
      if (i == bound)
      begin
         chk("flag wait", 1, 0);
         report_and_stop();
      end
      // let the load model log the last rise
      @(posedge mclk);
      @(negedge mclk);
   endtask

   initial
   begin
      pus_slots_s s;
      int c1;
      seed = 70;
      n_errors = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      req = 3'h0;
      slots = '0;
      run_mask = 4'h0;
      stby_mask = 4'h0;
      for (int b = 0; b < 4; b++)
      begin
         hw_reset();
         s = '0;
         s.sequencer_time_base = 2'(b);
         s.regulator_slot_code[0] = 8'h02;
         slots <= s;
         pulse(3'h1);
         wait_flag(3 * tcyc(b) + 20);
         chk("tbase rise", at(2, tcyc(b)), t_reg[0]);
         chk("reset release", at(3, tcyc(b)), t_rst);
      end
      $display("test time bases done");
      hw_reset();
      c1 = 3 + (xs() & 31);
      s = '0;
      s.sequencer_time_base = 2'h2;
      s.regulator_slot_code = {8'hff, 8'h00, 8'(c1), 8'h01};
      s.power_good_output_slot_code = 8'h02;
      slots <= s;
      pulse(3'h1);
      wait_flag(256 * T2 + 50);
      chk("reg0 rise", at(1, T2), t_reg[0]);
      chk("reg1 rise", at(c1, T2), t_reg[1]);
      chk("reg3 rise", at(255, T2), t_reg[3]);
      chk("reg2 off", -1, t_reg[2]);
      chk("power_good_pin rise", at(2, T2), t_pg);
      chk("reset late", at(256, T2), t_rst);
      chk("run state", 1, run_st);
      $display("test sequence done");
      @(posedge mclk);
      stby_mask <= 4'h1;
      run_mask <= 4'hb;
      pulse(3'h4);
      repeat (3) @(posedge mclk);
      pulse(3'h2);
      @(negedge mclk);
      chk("no bypass", 0, run_st);
      wait_flag(256 * T2 + 50);
      chk("reg1 again", at(c1, T2), t_reg[1]);
      chk("reg3 again", at(255, T2), t_reg[3]);
      chk("enables", 4'hb, reg_en);
      @(posedge mclk);
      stby_mask <= 4'hb;
      pulse(3'h4);
      repeat (3) @(posedge mclk);
      pulse(3'h2);
      @(negedge mclk);
      chk("volt apply", 1, volt);
      chk("flag bypass", 1, flag);
      chk("run bypass", 1, run_st);
      chk("enables kept", 4'hb, reg_en);
      $display("test standby done");
      hw_reset();
      slots <= '0;
      pulse(3'h1);
      @(posedge mclk);
      @(negedge mclk);
      chk("slave run", 1, run_st);
      chk("slave mode", 1, slave);
      chk("slave regs", 0, {pg, reg_en});
      chk("slave reset", 1, rst_o);
      $display("test slave done");
      report_and_stop();
   end
endmodule // test_power_up_slot_sequencer
